// >>> rtl/sls_status_regs.sv
`timescale 1ns/10ps
// How it works
// R1: inputs 0-11 in analog mode hold one flag at bit index, 1 when at or above threshold.
// R2: all fields read-only and read zero after reset until a measurement lands.
// R3: upper level register at offset 7h, reset zero, bits 23-13 read zero.
// R4: input 23 three-bit code at bits 12-10: 0 below 3A, 5 at/above high2.
// R5: input 23 codes 1..4 for bands 3A-3B, 3B-3C, 3C-high1, high1-high2.
// R6: inputs 22..18 two-bit codes at bits 9-8, 7-6, 5-4, 3-2, 1-0.
// R7: two-bit codes 0..3 by 3A, 3B, 3C; equality takes the higher code.
// R8: multi-level fields follow an input only in analog mode; input 23 has five thresholds.
// R9: matrix-scan register at offset 8h, reset zero, sense inputs 10-13.
// R10: scan bit is 1 when sense above threshold with its drive grounded, else 0.
// R11: scan bit index is (sense-10)*6 + (drive-4); bit 23 is sense 13 drive 9.
// R12: lower level register with flags for inputs 0-11 at offset 6h, reset zero.
// R13: reads have no side effect; values change only on a completed measurement or clear to zero while the input is out of analog mode.
module sls_status_regs #(
   parameter int ADC_W = sls_pkg::ADC_W
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [23:0] ANALOG_MODE,
   input wire logic [ADC_W*12-1:0] FLAG_THRESH,
   input wire logic [ADC_W-1:0] THRESH_3A,
   input wire logic [ADC_W-1:0] THRESH_3B,
   input wire logic [ADC_W-1:0] THRESH_3C,
   input wire logic [ADC_W-1:0] FIRST_HIGH_LIMIT,
   input wire logic [ADC_W-1:0] SECOND_HIGH_LIMIT,
   input wire logic MEAS_DONE,
   input wire logic [4:0] MEAS_INPUT,
   input wire logic [ADC_W-1:0] MEAS_LEVEL,
   input wire logic SCAN_DONE,
   input wire logic [1:0] SCAN_SENSE,
   input wire logic [2:0] SCAN_DRIVE,
   input wire logic [ADC_W-1:0] SCAN_LEVEL,
   input wire logic [ADC_W-1:0] SCAN_THRESH,
   input wire logic RD_EN,
   input wire logic [sls_pkg::ADDR_W-1:0] RD_ADDR,
   output logic [sls_pkg::DATA_W-1:0] RD_DATA,
   output logic RD_VALID
);

   logic [11:0] level_flag_r;
   logic [9:0] level_code_18_22_r;
   logic [2:0] level_code_input_23_r;
   logic [23:0] scan_r;
   logic [sls_pkg::DATA_W-1:0] rd_data_nxt;
   logic [ADC_W-1:0] flag_thresh_sel;
   logic [1:0] code2;
   logic [2:0] code23;
   logic [4:0] scan_idx;

   // three-threshold band, equality lands in the upper band
   function automatic logic [1:0] band3(input logic [ADC_W-1:0] lvl,
                                        input logic [ADC_W-1:0] a,
                                        input logic [ADC_W-1:0] b,
                                        input logic [ADC_W-1:0] c);
      logic [1:0] r;
      r = 2'h0;
      if (lvl >= c) begin
         r = 2'h3;
      end else if (lvl >= b) begin
         r = 2'h2;
      end else if (lvl >= a) begin
         r = 2'h1;
      end
      return r;
   endfunction

   always_comb begin
      flag_thresh_sel = '0;
      if (MEAS_INPUT < 5'(sls_pkg::NUM_FLAG_INPUTS)) begin
         flag_thresh_sel = FLAG_THRESH[MEAS_INPUT*ADC_W +: ADC_W];
      end
      code2 = band3(MEAS_LEVEL, THRESH_3A, THRESH_3B, THRESH_3C); // see R7
      // see R4 see R5
      if (MEAS_LEVEL >= SECOND_HIGH_LIMIT) begin
         code23 = sls_pkg::CODE_ABOVE_HIGH2;
      end else if (MEAS_LEVEL >= FIRST_HIGH_LIMIT) begin
         code23 = sls_pkg::CODE_HIGH1_HIGH2;
      end else begin
         code23 = {1'b0, code2};
      end
      // see R11
      scan_idx = 5'(SCAN_SENSE * 3'(sls_pkg::NUM_DRIVES)) + 5'(SCAN_DRIVE);
   end

   // single-threshold flags, inputs 0-11
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         level_flag_r <= 12'h000; // see R2
      end else begin
         for (int i = 0; i < sls_pkg::NUM_FLAG_INPUTS; i++) begin
            if (!ANALOG_MODE[i]) begin
               level_flag_r[i] <= 1'b0; // see R8
            end else if (MEAS_DONE && MEAS_INPUT == 5'(i)) begin
               // at or above threshold counts as above
               level_flag_r[i] <= (MEAS_LEVEL >= flag_thresh_sel); // see R1 see R13
            end
         end
      end
   end

   // two-bit codes, inputs 18-22
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         level_code_18_22_r <= 10'h000; // see R2
      end else begin
         for (int k = 0; k < sls_pkg::NUM_CODE2_INPUTS; k++) begin
            if (!ANALOG_MODE[sls_pkg::FIRST_CODE_INPUT + k]) begin
               level_code_18_22_r[2*k +: 2] <= 2'h0; // see R8
            end else if (MEAS_DONE && MEAS_INPUT == 5'(sls_pkg::FIRST_CODE_INPUT + k)) begin
               level_code_18_22_r[2*k +: 2] <= code2; // see R6 see R13
            end
         end
      end
   end

   // five-threshold code, input 23
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         level_code_input_23_r <= 3'h0; // see R2
      end else if (!ANALOG_MODE[sls_pkg::TOP_INPUT]) begin
         level_code_input_23_r <= 3'h0; // see R8
      end else if (MEAS_DONE && MEAS_INPUT == 5'(sls_pkg::TOP_INPUT)) begin
         level_code_input_23_r <= code23; // see R4 see R13
      end
   end

   // matrix scan; out-of-range pairs ignored rather than aliasing
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         scan_r <= sls_pkg::RESET_VALUE; // see R9
      end else if (SCAN_DONE && SCAN_DRIVE < 3'(sls_pkg::NUM_DRIVES)) begin
         scan_r[scan_idx] <= (SCAN_LEVEL > SCAN_THRESH); // see R10 see R11
      end
   end

   // read path only samples; nothing is cleared by a read
   always_comb begin
      rd_data_nxt = '0;
      if (RD_ADDR == sls_pkg::OFS_LEVEL_LOWER) begin
         rd_data_nxt = {12'h000, level_flag_r}; // see R12
      end else if (RD_ADDR == sls_pkg::OFS_LEVEL_UPPER) begin
         rd_data_nxt = {11'h000, level_code_input_23_r, level_code_18_22_r}; // see R3
      end else if (RD_ADDR == sls_pkg::OFS_SCAN_LOW) begin
         rd_data_nxt = scan_r; // see R9
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         RD_DATA <= sls_pkg::RESET_VALUE;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
         if (RD_EN) begin
            RD_DATA <= rd_data_nxt; // see R13
         end
      end
   end

endmodule

// >>> rtl/sls_pkg.sv
package sls_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 24;
   localparam int ADC_W = 10;
   localparam logic [3:0] OFS_LEVEL_LOWER = 4'h6;
   localparam logic [3:0] OFS_LEVEL_UPPER = 4'h7;
   localparam logic [3:0] OFS_SCAN_LOW = 4'h8;
   localparam logic [23:0] RESET_VALUE = 24'h000000;
   localparam int NUM_FLAG_INPUTS = 12;
   localparam int FIRST_CODE_INPUT = 18;
   localparam int NUM_CODE2_INPUTS = 5;
   localparam int TOP_INPUT = 23;
   localparam int CODE23_LSB = 10;
   localparam int FIRST_SENSE = 10;
   localparam int FIRST_DRIVE = 4;
   localparam int NUM_DRIVES = 6;
   localparam int NUM_SENSES = 4;
   localparam logic [2:0] CODE_BELOW_3A = 3'h0;
   localparam logic [2:0] CODE_3A_3B = 3'h1;
   localparam logic [2:0] CODE_3B_3C = 3'h2;
   localparam logic [2:0] CODE_3C_HIGH1 = 3'h3;
   localparam logic [2:0] CODE_HIGH1_HIGH2 = 3'h4;
   localparam logic [2:0] CODE_ABOVE_HIGH2 = 3'h5;
endpackage

// >>> verif/sls_status_checker.sv
`timescale 1ns/10ps
module sls_status_checker (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [23:0] ANALOG_MODE,
   input wire logic MEAS_DONE,
   input wire logic SCAN_DONE,
   input wire logic RD_EN,
   input wire logic [3:0] RD_ADDR,
   input wire logic [23:0] RD_DATA,
   input wire logic RD_VALID
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   chk_valid_pulse: assert property (RD_EN |=> RD_VALID)
      else $error("read gave no valid");
   chk_no_extra_valid: assert property (!RD_EN |=> !RD_VALID)
      else $error("valid without read");
   chk_upper_reserved: assert property (RD_EN && RD_ADDR == 4'h7
      |=> RD_DATA[23:13] == 11'h000) else $error("upper reserved bits set");
   chk_lower_unused: assert property (RD_EN && RD_ADDR == 4'h6
      |=> RD_DATA[23:12] == 12'h000) else $error("lower unused bits set");
   chk_code_range: assert property (RD_EN && RD_ADDR == 4'h7 |=> RD_DATA[12:10] <= 3'h5)
      else $error("input 23 code out of range");
   chk_unmapped_zero: assert property (RD_EN && (RD_ADDR < 4'h6 || RD_ADDR > 4'h8)
      |=> RD_DATA == 24'h000000) else $error("unmapped read not zero");
   chk_reset_clear: assert property ($fell(RESET)
      |-> RD_DATA == 24'h000000 && !RD_VALID) else $error("read port not clear after reset");
   // a repeated read with nothing measured meanwhile must return the same image
   chk_read_no_effect: assert property (RD_EN && $past(RD_EN)
      && RD_ADDR == $past(RD_ADDR) && !$past(MEAS_DONE) && !$past(SCAN_DONE)
      && $past(ANALOG_MODE) == $past(ANALOG_MODE, 2)
      |=> $stable(RD_DATA)) else $error("read changed stored value");
   cover property (MEAS_DONE && ANALOG_MODE[23]);
   cover property (SCAN_DONE);
   cover property (RD_EN && RD_ADDR == 4'h8);
endmodule
bind sls_status_regs sls_status_checker u_sls_status_checker (.CLK_SYS, .RESET, .ANALOG_MODE,
   .MEAS_DONE, .SCAN_DONE, .RD_EN, .RD_ADDR, .RD_DATA, .RD_VALID);

// >>> verif/sls_host_model.sv
`timescale 1ns/10ps
module sls_host_model (
   input wire logic CLK_SYS,
   input wire logic [23:0] RD_DATA,
   input wire logic RD_VALID,
   output logic RD_EN = 1'b0,
   output logic [3:0] RD_ADDR = 4'h0
);
   // leaves the request up so that reads can run back to back
   task automatic read(input logic [3:0] a, output logic [23:0] d);
      {RD_EN, RD_ADDR} = {1'b1, a};
      @(posedge CLK_SYS) #2;
      d = (RD_VALID === 1'b1) ? RD_DATA : 24'hxxxxxx;
   endtask
   // released address shows its inverse, not the stale value
   task automatic stop();
      {RD_EN, RD_ADDR} = {1'b0, ~RD_ADDR};
      @(posedge CLK_SYS) #2;
   endtask
endmodule

// >>> verif/sls_status_regs_test.sv
`timescale 1ns/10ps
module sls_status_regs_test;
   logic CLK_SYS = 1'b0, RESET = 1'b1, md = 1'b0, sd = 1'b0, rvalid, ren;
   logic [23:0] mode = 24'hffffff, rdata, exp_r [6:8];
   logic [119:0] fth = '0;
   logic [4:0] mi = 5'h00;
   logic [9:0] ml = 10'h000, sl = 10'h000, st = 10'h000;
   logic [1:0] ss = 2'h0;
   logic [2:0] sdr = 3'h0;
   logic [3:0] raddr;
   int fails = 0, check_count = 0, cyc = 0, lv;
   int th [5] = '{100, 200, 300, 400, 500};
   always #25 CLK_SYS = ~CLK_SYS;
   sls_status_regs u_sls_status_regs (.CLK_SYS, .RESET, .ANALOG_MODE(mode), .FLAG_THRESH(fth),
      .THRESH_3A(10'h064), .THRESH_3B(10'h0c8), .THRESH_3C(10'h12c), .FIRST_HIGH_LIMIT(10'h190),
      .SECOND_HIGH_LIMIT(10'h1f4), .MEAS_DONE(md), .MEAS_INPUT(mi), .MEAS_LEVEL(ml),
      .SCAN_DONE(sd), .SCAN_SENSE(ss), .SCAN_DRIVE(sdr), .SCAN_LEVEL(sl), .SCAN_THRESH(st),
      .RD_EN(ren), .RD_ADDR(raddr), .RD_DATA(rdata), .RD_VALID(rvalid));
   sls_host_model u_sls_host_model (.CLK_SYS, .RD_DATA(rdata), .RD_VALID(rvalid),
      .RD_EN(ren), .RD_ADDR(raddr));
   function automatic int code(int v, int n);
      int c = 0;
      for (int k = 0; k < n; k++) c += (v >= th[k]);
      return c;
   endfunction
   task automatic cmp(int a);
      logic [23:0] g, e;
      e = (a > 5 && a < 9) ? exp_r[a] : 24'h000000;
      u_sls_host_model.read(4'(a), g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic strobe(int i, int s, int d, int l2, int t2);
      {md, mi, ml, sd, ss} = {1'b1, 5'(i), 10'(lv), 1'b1, 2'(s)};
      {sdr, sl, st} = {3'(d), 10'(l2), 10'(t2)};
      if (mode[i] && i < 12) exp_r[6][i] = lv >= fth[i*10+:10];
      if (mode[i] && i > 17 && i < 23) exp_r[7][(i-18)*2+:2] = 2'(code(lv, 3));
      if (mode[i] && i == 23) exp_r[7][12:10] = 3'(code(lv, 5));
      if (d < 6) exp_r[8][s*6+d] = l2 > t2;
      // strobes stay up between back-to-back calls; the caller lowers them
      @(posedge CLK_SYS) #2;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(63));
      // half the flag thresholds sit on the near-threshold levels to hit equality
      for (int k = 0; k < 12; k++) fth[k*10+:10] = (k < 6) ? 10'(th[k % 5]) : 10'($urandom);
      exp_r = '{default: 24'h000000};
      repeat (10) @(posedge CLK_SYS);
      #2 RESET = 1'b0;
      for (int a = 0; a < 16; a++) cmp(a);
      u_sls_host_model.stop();
      $display("test reset values done");
      repeat (2) begin
         repeat (150) begin
            lv = $urandom % 1022 + 1;
            strobe($urandom % 24, $urandom % 4, $urandom % 8, lv, lv + $urandom % 3 - 1);
            lv = th[$urandom % 5] + $urandom % 3 - 1;
            strobe($urandom % 24, $urandom % 4, 7, 0, 0);
            {md, sd} = 2'b00;
            for (int a = 6; a < 10; a++) cmp(a > 8 ? 8 : a);
            u_sls_host_model.stop();
         end
         mode = 24'($urandom);
         exp_r[6] &= {12'h000, mode[11:0]};
         for (int k = 0; k < 5; k++) if (!mode[18+k]) exp_r[7][k*2+:2] = 2'h0;
         if (!mode[23]) exp_r[7][12:10] = 3'h0;
         $display("test measurement pass done");
      end
      RESET = 1'b1;
      @(posedge CLK_SYS) #2 RESET = 1'b0;
      exp_r = '{default: 24'h000000};
      for (int a = 6; a < 9; a++) cmp(a);
      $display("test mid reset done");
      report_and_stop();
   end
endmodule
